// ### dsp_host_io_mailbox.sv
// mailbox between a signal processor bus and a card host bus, with shared registers
//
// Summary of operation
// - decode registers at processor and host addresses
// - shared 8-bit address register, both read/write
// - shared 8-bit data register, both read/write
// - flags read-only, bits 5:2 read zero
// - processor write sets host pending, drives interrupt
// - host pending recorded in card interrupt bit
// - host read of address/data clears host pending
// - host write sets processor pending indicator
// - processor read of address/data clears it
// - data write sets bit 1, reader clears
// - address write sets bit 0, reader clears
// - seven-state sequencer, idle after reset
// - host strobes synchronised before use
// - processor select enters processor branch, blocks host
// - address-wait picks read or write phase
// - read phase drives register onto processor bus
// - write phase captures processor data, returns idle
// - host request enters host address-wait, then phase
`timescale 1ns/10ps
`include "mbx_defs.svh"
module dsp_host_io_mailbox
	import mbx_pkg::*;
#(
	parameter int DATA_W      = 8,
	parameter int PROC_ADDR_W = 14,
	parameter int HOST_ADDR_W = 11
) (
	input  wire logic                   clock_in,        // 80 MHz processor clock
	input  wire logic                   sys_rst_in,      // card reset, synchronous, active high
	input  wire logic                   proc_sel_n_in,   // processor i/o select, active low
	input  wire logic                   proc_rd_n_in,    // processor read strobe, active low
	input  wire logic                   proc_wr_n_in,    // processor write strobe, active low
	input  wire logic [PROC_ADDR_W-1:0] proc_addr_in,    // processor address
	input  wire logic [DATA_W-1:0]      proc_data_in,    // processor data bus, input side
	output logic      [DATA_W-1:0]      proc_data_out,   // processor data bus, output side
	output logic                        proc_data_oe_out, // high while driving processor bus
	input  wire logic                   host_rd_n_in,    // host read strobe, async, active low
	input  wire logic                   host_wr_n_in,    // host write strobe, async, active low
	input  wire logic [HOST_ADDR_W-1:0] host_addr_in,    // host address, stable with strobe
	input  wire logic [DATA_W-1:0]      host_data_in,    // host data bus, input side
	output logic      [DATA_W-1:0]      host_data_out,   // host data bus, output side
	output logic                        host_data_oe_out, // high while driving host bus
	input  wire logic                   io_enable_in,    // interrupt routing enabled; host register decode does not use it
	output logic                        host_irq_n_out,  // host interrupt, active low
	output logic                        card_int_out     // pending interrupt for card status bit
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PROC_ADDR,
		ST_PROC_READ,
		ST_PROC_WRITE,
		ST_HOST_ADDR_WAIT,
		ST_HOST_READ,
		ST_HOST_WRITE
	} seq_state_t;

	seq_state_t state_q;
	seq_state_t state_d;

	logic [DATA_W-1:0] mailbox_address_q;
	logic [DATA_W-1:0] mailbox_data_q;
	logic [DATA_W-1:0] proc_rdata_q;
	logic [DATA_W-1:0] host_rdata_q;
	logic              proc_oe_q;
	logic              host_oe_q;
	logic              irq_n_q;
	logic              card_int_q;
	mbx_flags_t        flags_q;
	mbx_flags_t        flags_d;
	logic              addr_by_host_q; // last address write came from the host
	logic              data_by_host_q; // last data write came from the host

	// host strobes come from an unclocked bus, so each passes the filtered synchroniser
	logic host_rd_n_s;
	logic host_wr_n_s;

	strobe_sync #(
		.RESET_LEVEL(1'b1)
	) u_sync_rd (
		.clock_in  (clock_in),
		.sys_rst_in(sys_rst_in),
		.async_in  (host_rd_n_in),
		.level_out (host_rd_n_s)
	);

	strobe_sync #(
		.RESET_LEVEL(1'b1)
	) u_sync_wr (
		.clock_in  (clock_in),
		.sys_rst_in(sys_rst_in),
		.async_in  (host_wr_n_in),
		.level_out (host_wr_n_s)
	);

	// host address and data are pins as well, so they take the strobes' path and arrive with them;
	// a bit that resolves a cycle late is covered by the address-wait cycle before the match is used
	logic [HOST_ADDR_W-1:0] host_addr_s;
	logic [DATA_W-1:0]      host_data_s;

	for (genvar gi = 0; gi < HOST_ADDR_W; gi++) begin : g_addr_sync
		strobe_sync #(
			.RESET_LEVEL(1'b0)
		) u_sync_bit (
			.clock_in  (clock_in),
			.sys_rst_in(sys_rst_in),
			.async_in  (host_addr_in[gi]),
			.level_out (host_addr_s[gi])
		);
	end

	for (genvar gj = 0; gj < DATA_W; gj++) begin : g_data_sync
		strobe_sync #(
			.RESET_LEVEL(1'b0)
		) u_sync_bit (
			.clock_in  (clock_in),
			.sys_rst_in(sys_rst_in),
			.async_in  (host_data_in[gj]),
			.level_out (host_data_s[gj])
		);
	end

	// processor pins are on this clock so they are used directly
	wire proc_req  = ~proc_sel_n_in;
	wire host_req  = ~host_rd_n_s | ~host_wr_n_s;
	wire proc_rd   = ~proc_rd_n_in;
	wire proc_wr   = ~proc_wr_n_in;
	wire host_rd   = ~host_rd_n_s;
	wire host_wr   = ~host_wr_n_s;

	// address decode for both maps onto the same three registers
	wire proc_hit_addr  = (proc_addr_in == `PROC_ADDR_OFS);
	wire proc_hit_data  = (proc_addr_in == `PROC_DATA_OFS);
	wire proc_hit_flags = (proc_addr_in == `PROC_FLAGS_OFS);
	wire host_hit_addr  = (host_addr_s == `HOST_ADDR_OFS);
	wire host_hit_data  = (host_addr_s == `HOST_DATA_OFS);
	wire host_hit_flags = (host_addr_s == `HOST_FLAGS_OFS);
	wire proc_match     = proc_hit_addr | proc_hit_data | proc_hit_flags;
	wire host_match     = host_hit_addr | host_hit_data | host_hit_flags;

	wire reg_sel_t proc_sel = proc_hit_addr ? SEL_ADDR : proc_hit_data ? SEL_DATA :
		proc_hit_flags ? SEL_FLAGS : SEL_NONE;
	wire reg_sel_t host_sel = host_hit_addr ? SEL_ADDR : host_hit_data ? SEL_DATA :
		host_hit_flags ? SEL_FLAGS : SEL_NONE;

	// flag register image: reserved bits read zero
	wire [DATA_W-1:0] flags_image = {flags_q.host_mail_pending, flags_q.proc_mail_pending,
		4'h0, flags_q.data_written_flag, flags_q.addr_written_flag};

	// access events: each fires once, on entry into its phase
	wire phase_entry    = (state_q != state_d);
	wire proc_rd_ev     = phase_entry && (state_d == ST_PROC_READ);
	wire proc_wr_ev     = phase_entry && (state_d == ST_PROC_WRITE);
	wire host_rd_ev     = phase_entry && (state_d == ST_HOST_READ);
	wire host_wr_ev     = phase_entry && (state_d == ST_HOST_WRITE);

	// a writer is locked out while its own side still has unread mail
	wire proc_wr_ok     = proc_wr_ev && !flags_q.proc_mail_pending;
	wire host_wr_ok     = host_wr_ev && !flags_q.host_mail_pending;
	wire proc_wr_addr   = proc_wr_ok && (proc_sel == SEL_ADDR);
	wire proc_wr_data   = proc_wr_ok && (proc_sel == SEL_DATA);
	wire host_wr_addr   = host_wr_ok && (host_sel == SEL_ADDR);
	wire host_wr_data   = host_wr_ok && (host_sel == SEL_DATA);
	wire proc_rd_addr   = proc_rd_ev && (proc_sel == SEL_ADDR);
	wire proc_rd_data   = proc_rd_ev && (proc_sel == SEL_DATA);
	wire host_rd_addr   = host_rd_ev && (host_sel == SEL_ADDR);
	wire host_rd_data   = host_rd_ev && (host_sel == SEL_DATA);

	// a written flag is cleared only by the receiving side, not by the writer reading back
	wire addr_taken     = addr_by_host_q ? proc_rd_addr : host_rd_addr;
	wire data_taken     = data_by_host_q ? proc_rd_data : host_rd_data;

	// sequencer next state; processor wins a tie in idle, host stays pending
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				if (proc_req) begin
					state_d = ST_PROC_ADDR;
				end else if (host_req) begin
					state_d = ST_HOST_ADDR_WAIT;
				end
			end
			ST_PROC_ADDR: begin
				if (!proc_req) begin
					state_d = ST_IDLE;
				end else if (proc_match && proc_rd) begin
					state_d = ST_PROC_READ;
				end else if (proc_match && proc_wr) begin
					state_d = ST_PROC_WRITE;
				end
			end
			ST_PROC_READ: begin
				if (!proc_rd || !proc_req) begin
					state_d = ST_IDLE;
				end
			end
			ST_PROC_WRITE: begin
				state_d = ST_IDLE;
			end
			ST_HOST_ADDR_WAIT: begin
				if (!host_req) begin
					state_d = ST_IDLE;
				end else if (host_match && host_rd) begin
					state_d = ST_HOST_READ;
				end else if (host_match && host_wr) begin
					state_d = ST_HOST_WRITE;
				end
			end
			ST_HOST_READ: begin
				if (!host_rd) begin
					state_d = ST_IDLE;
				end
			end
			ST_HOST_WRITE: begin
				if (!host_wr) begin
					state_d = ST_IDLE;
				end
			end
		endcase
	end

	// sequencer register, idle on card reset
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// flag next value: a set in the same cycle as a clear wins
	always_comb begin
		flags_d = flags_q;
		if (host_rd_addr || host_rd_data) begin
			flags_d.host_mail_pending = 1'b0;
		end
		if (proc_rd_addr || proc_rd_data) begin
			flags_d.proc_mail_pending = 1'b0;
		end
		if (data_taken) begin
			flags_d.data_written_flag = 1'b0;
		end
		if (addr_taken) begin
			flags_d.addr_written_flag = 1'b0;
		end
		if (proc_wr_addr || proc_wr_data) begin
			flags_d.host_mail_pending = 1'b1;
		end
		if (host_wr_addr || host_wr_data) begin
			flags_d.proc_mail_pending = 1'b1;
		end
		if (proc_wr_data || host_wr_data) begin
			flags_d.data_written_flag = 1'b1;
		end
		if (proc_wr_addr || host_wr_addr) begin
			flags_d.addr_written_flag = 1'b1;
		end
	end

	// flags cleared by card reset
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	// shared address and data registers; writes to the flag address fall through
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			mailbox_address_q <= `MBX_REG_RESET;
			mailbox_data_q    <= `MBX_REG_RESET;
			addr_by_host_q    <= 1'b0;
			data_by_host_q    <= 1'b0;
		end else begin
			if (proc_wr_addr) begin
				mailbox_address_q <= proc_data_in;
				addr_by_host_q    <= 1'b0;
			end else if (host_wr_addr) begin
				mailbox_address_q <= host_data_s;
				addr_by_host_q    <= 1'b1;
			end
			if (proc_wr_data) begin
				mailbox_data_q <= proc_data_in;
				data_by_host_q <= 1'b0;
			end else if (host_wr_data) begin
				mailbox_data_q <= host_data_s;
				data_by_host_q <= 1'b1;
			end
		end
	end

	// read data muxes, captured at phase entry so the bus holds steady through the phase
	wire [DATA_W-1:0] proc_mux = (proc_sel == SEL_ADDR) ? mailbox_address_q :
		(proc_sel == SEL_DATA) ? mailbox_data_q : flags_image;
	wire [DATA_W-1:0] host_mux = (host_sel == SEL_ADDR) ? mailbox_address_q :
		(host_sel == SEL_DATA) ? mailbox_data_q : flags_image;

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			proc_rdata_q <= `MBX_REG_RESET;
			host_rdata_q <= `MBX_REG_RESET;
		end else begin
			if (proc_rd_ev) begin
				proc_rdata_q <= proc_mux;
			end
			if (host_rd_ev) begin
				host_rdata_q <= host_mux;
			end
		end
	end

	// bus enables follow the read phases; host is never driven in the processor branch
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			proc_oe_q <= 1'b0;
			host_oe_q <= 1'b0;
		end else begin
			proc_oe_q <= (state_d == ST_PROC_READ);
			host_oe_q <= (state_d == ST_HOST_READ);
		end
	end

	// interrupt pin gated by enable; card bit records pending regardless
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			irq_n_q    <= 1'b1;
			card_int_q <= 1'b0;
		end else begin
			irq_n_q    <= ~(flags_d.host_mail_pending & io_enable_in);
			card_int_q <= flags_d.host_mail_pending;
		end
	end

	assign proc_data_out    = proc_rdata_q;
	assign proc_data_oe_out = proc_oe_q;
	assign host_data_out    = host_rdata_q;
	assign host_data_oe_out = host_oe_q;
	assign host_irq_n_out   = irq_n_q;
	assign card_int_out     = card_int_q;
endmodule

// ### mbx_defs.svh
// register offsets, flag bit positions and timing constants for the mailbox
`ifndef MBX_DEFS_SVH
`define MBX_DEFS_SVH
`define PROC_ADDR_OFS   14'h0001
`define PROC_DATA_OFS   14'h0002
`define PROC_FLAGS_OFS  14'h0003
`define HOST_ADDR_OFS   11'h400
`define HOST_DATA_OFS   11'h401
`define HOST_FLAGS_OFS  11'h402
`define FLAG_HOST_BIT   7
`define FLAG_PROC_BIT   6
`define FLAG_DATA_BIT   1
`define FLAG_ADDR_BIT   0
`define MBX_REG_RESET   8'h00
`define CLK_FREQ_MHZ    80
`endif

// ### mbx_pkg.sv
// types shared by the mailbox files
package mbx_pkg;
	typedef enum logic [1:0] {
		SEL_NONE,
		SEL_ADDR,
		SEL_DATA,
		SEL_FLAGS
	} reg_sel_t;

	typedef struct packed {
		logic host_mail_pending;
		logic proc_mail_pending;
		logic data_written_flag;
		logic addr_written_flag;
	} mbx_flags_t;
endpackage

// ### strobe_sync.sv
// three-stage synchroniser for one asynchronous level, with agreement filter
`timescale 1ns/10ps
module strobe_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic clock_in,   // block clock
	input  wire logic sys_rst_in, // synchronous reset, active high
	input  wire logic async_in,   // raw pin level
	output logic      level_out   // filtered level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	// the first stage feeds only the second; the level moves once stages two and three agree
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			s1_q  <= RESET_LEVEL;
			s2_q  <= RESET_LEVEL;
			s3_q  <= RESET_LEVEL;
			lvl_q <= RESET_LEVEL;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				lvl_q <= s3_q;
			end
		end
	end

	assign level_out = lvl_q;
endmodule

// ### mbx_checker.sv
// port assertions for the mailbox
`timescale 1ns/10ps
module mbx_checker (
	input wire logic        clock_in,         // clock
	input wire logic        sys_rst_in,       // reset
	input wire logic        proc_sel_n_in,    // select
	input wire logic        proc_rd_n_in,     // read
	input wire logic        proc_wr_n_in,     // write
	input wire logic [13:0] proc_addr_in,     // address
	input wire logic [7:0]  proc_data_out,    // read data
	input wire logic        proc_data_oe_out, // drive
	input wire logic        host_rd_n_in,     // read
	input wire logic        host_data_oe_out, // drive
	input wire logic        io_enable_in,     // enable
	input wire logic        host_irq_n_out,   // interrupt
	input wire logic        card_int_out      // pending
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (sys_rst_in);
	// nothing pending or driven on the first edge out of reset
	AST_RST_QUIET: assert property ($past(sys_rst_in) |-> host_irq_n_out && !card_int_out)
		else $error("active after reset");
	// the pin may only follow the status bit, and only while enabled
	AST_IRQ_CARD: assert property (!host_irq_n_out |-> card_int_out)
		else $error("irq without card int");
	AST_IRQ_EN: assert property (!host_irq_n_out |-> $past(io_enable_in) || $past(io_enable_in, 2))
		else $error("irq while disabled");
	// host mail can only come from a processor write strobe
	AST_INT_SRC: assert property ($rose(card_int_out) |-> !$past(proc_wr_n_in) || !$past(proc_wr_n_in, 2))
		else $error("card int without write");
	// one bus owner at a time
	AST_OE_EXCL: assert property (!(proc_data_oe_out && host_data_oe_out))
		else $error("both buses driven");
	AST_PROC_OE: assert property (proc_data_oe_out |-> !$past(proc_rd_n_in, 2) && !$past(proc_sel_n_in, 2))
		else $error("processor bus driven without read");
	// synchroniser delay: a host read cannot be answered within four edges
	AST_HOST_OE: assert property ($rose(host_data_oe_out) |-> !$past(host_rd_n_in, 4))
		else $error("host answer too early");
	// the bench moves the address as it releases the strobe, so the read address is one edge back
	AST_RSVD: assert property (proc_data_oe_out && $past(proc_addr_in) == 14'h0003 |-> proc_data_out[5:2] == 4'h0)
		else $error("reserved flag bits set");
endmodule
bind dsp_host_io_mailbox mbx_checker u_chk (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
	.proc_sel_n_in(proc_sel_n_in), .proc_rd_n_in(proc_rd_n_in), .proc_wr_n_in(proc_wr_n_in),
	.proc_addr_in(proc_addr_in), .proc_data_out(proc_data_out), .proc_data_oe_out(proc_data_oe_out),
	.host_rd_n_in(host_rd_n_in), .host_data_oe_out(host_data_oe_out), .io_enable_in(io_enable_in),
	.host_irq_n_out(host_irq_n_out), .card_int_out(card_int_out));

// ### host_adapter_model.sv
// host bus adapter model: released lines show inverted values
`timescale 1ns/10ps
module host_adapter_model (
	input  wire logic        clock_in,           // pacing clock
	input  wire logic        oe_in,              // mailbox drives data
	input  wire logic [7:0]  rdata_in,           // read data
	output logic             rd_n_out = 1'b1,    // read strobe
	output logic             wr_n_out = 1'b1,    // write strobe
	output logic      [10:0] addr_out = 11'h7ff, // address
	output logic      [7:0]  wdata_out = 8'h00   // write data
);
	// a write has no answer, so its strobe is held well past the synchroniser
	task automatic xfer(input logic wr, input logic [10:0] a, inout logic [7:0] d, output logic ok);
		int i;
		@(negedge clock_in);
		addr_out = a;
		wdata_out = d;
		{rd_n_out, wr_n_out} = {wr, !wr};
		for (i = 0; i < 60 && !(wr ? i == 12 : oe_in === 1'b1); i++)
			@(negedge clock_in);
		ok = wr || oe_in === 1'b1;
		d = wr ? d : rdata_in;
		{rd_n_out, wr_n_out} = 2'b11;
		addr_out = ~a;
		wdata_out = ~wdata_out;
		repeat (8) @(negedge clock_in);
	endtask
endmodule

// ### test_dsp_host_io_mailbox.sv
// bench for the mailbox: processor bus driven here, host side by its model
`timescale 1ns/10ps
module test_dsp_host_io_mailbox;
	logic        clock_in, sys_rst_in, proc_sel_n_in, proc_rd_n_in, proc_wr_n_in, io_enable_in, proc_data_oe_out;
	logic        host_data_oe_out, host_rd_n_in, host_wr_n_in, host_irq_n_out, card_int_out;
	logic [13:0] proc_addr_in;
	logic [10:0] host_addr_in;
	logic [7:0]  proc_data_in, proc_data_out, host_data_in, host_data_out, v;
	int          failures = 0, check_count = 0;
	// design with its host bus joined to the adapter model
	dsp_host_io_mailbox u_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .proc_sel_n_in(proc_sel_n_in),
		.proc_rd_n_in(proc_rd_n_in), .proc_wr_n_in(proc_wr_n_in), .proc_addr_in(proc_addr_in),
		.proc_data_in(proc_data_in), .proc_data_out(proc_data_out), .proc_data_oe_out(proc_data_oe_out),
		.host_rd_n_in(host_rd_n_in), .host_wr_n_in(host_wr_n_in), .host_addr_in(host_addr_in),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe_out(host_data_oe_out),
		.io_enable_in(io_enable_in), .host_irq_n_out(host_irq_n_out), .card_int_out(card_int_out));
	host_adapter_model u_host (.clock_in(clock_in), .oe_in(host_data_oe_out), .rdata_in(host_data_out),
		.rd_n_out(host_rd_n_in), .wr_n_out(host_wr_n_in), .addr_out(host_addr_in), .wdata_out(host_data_in));
	// count and compare
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test;
		$display("%0d checks, %0d failures", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// processor access; a write holds its strobe over two edges and is then released
	task automatic px(input logic wr, input logic [13:0] a, input logic [7:0] w);
		int i;
		@(negedge clock_in);
		proc_addr_in = a;
		proc_data_in = w;
		proc_sel_n_in = 1'b0;
		{proc_rd_n_in, proc_wr_n_in} = {wr, !wr};
		for (i = 0; i < 10 && !(wr ? i == 2 : proc_data_oe_out === 1'b1); i++)
			@(negedge clock_in);
		v = proc_data_out;
		if (!wr)
			chk("proc answer", 8'h01, proc_data_oe_out);
		if (!wr && proc_data_oe_out !== 1'b1)
			finish_test();
		{proc_sel_n_in, proc_rd_n_in, proc_wr_n_in} = 3'b111;
		proc_addr_in = ~a;
		proc_data_in = ~w;
		repeat (3) @(negedge clock_in);
	endtask
	// host access through the model; a missing answer ends the run
	task automatic hx(input logic wr, input logic [10:0] a, input logic [7:0] w);
		logic k;
		v = w;
		u_host.xfer(wr, a, v, k);
		chk("host answer", 8'h01, k);
		if (k !== 1'b1)
			finish_test();
	endtask
	// processor parked on an unmapped address keeps the host waiting
	task automatic s_block;
		@(negedge clock_in);
		proc_sel_n_in = 1'b0;
		fork
			hx(1'b0, 11'h402, 8'h00);
			begin
				repeat (20) @(negedge clock_in);
				chk("host oe", 8'h00, host_data_oe_out);
				proc_sel_n_in = 1'b1;
			end
		join
		chk("flags", 8'h00, v);
	endtask
	// processor mail: interrupt, host write lockout, cleared by host reads
	task automatic s_p2h;
		px(1'b1, 14'h0001, 8'ha5);
		px(1'b1, 14'h0002, 8'h3c);
		chk("irq", 8'h00, host_irq_n_out);
		io_enable_in = 1'b0;
		hx(1'b0, 11'h402, 8'h00);
		chk("host flags", 8'h83, v);
		chk("irq off", 8'h01, host_irq_n_out);
		chk("card int", 8'h01, card_int_out);
		hx(1'b1, 11'h401, 8'hff);
		hx(1'b0, 11'h400, 8'h00);
		chk("host addr", 8'ha5, v);
		hx(1'b0, 11'h402, 8'h00);
		chk("host flags", 8'h02, v);
		chk("card int clear", 8'h00, card_int_out);
		hx(1'b0, 11'h401, 8'h00);
		chk("host data", 8'h3c, v);
		io_enable_in = 1'b1;
	endtask
	// host mail: indicator only; the processor writes only once its pending flag is clear; flags ignore writes
	task automatic s_h2p;
		hx(1'b1, 11'h400, 8'h5a);
		hx(1'b1, 11'h401, 8'hc3);
		px(1'b0, 14'h0003, 8'h00);
		chk("flags", 8'h43, v);
		px(1'b0, 14'h0002, 8'h00);
		chk("data", 8'hc3, v);
		px(1'b0, 14'h0003, 8'h00);
		chk("flags", 8'h01, v);
		px(1'b1, 14'h0003, 8'hff);
		px(1'b0, 14'h0001, 8'h00);
		chk("addr", 8'h5a, v);
		px(1'b0, 14'h0003, 8'h00);
		chk("flags", 8'h00, v);
	endtask
	// a writer reading back keeps its written flag; a card reset in mid-run clears every flag
	task automatic s_reset;
		px(1'b1, 14'h0002, 8'h77);
		px(1'b0, 14'h0002, 8'h00);
		chk("own data", 8'h77, v);
		px(1'b0, 14'h0003, 8'h00);
		chk("flags", 8'h82, v);
		chk("irq", 8'h00, host_irq_n_out);
		@(negedge clock_in);
		sys_rst_in = 1'b1;
		repeat (16) @(negedge clock_in);
		sys_rst_in = 1'b0;
		chk("irq reset", 8'h01, host_irq_n_out);
		chk("card int reset", 8'h00, card_int_out);
		repeat (5) @(negedge clock_in);
		px(1'b0, 14'h0003, 8'h00);
		chk("flags reset", 8'h00, v);
	endtask
	// free-running clock
	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end
	// reset, then the scenarios
	initial begin
		sys_rst_in = 1'b1;
		{proc_sel_n_in, proc_rd_n_in, proc_wr_n_in, io_enable_in} = 4'hf;
		proc_addr_in = 14'h0000;
		proc_data_in = 8'h00;
		repeat (16) @(negedge clock_in);
		sys_rst_in = 1'b0;
		repeat (5) @(negedge clock_in);
		s_block();
		s_p2h();
		s_h2p();
		s_reset();
		finish_test();
	end
endmodule
